// ===== core/cpc_defines.svh
/*
 * Constants of the processor clock divisor and power control block:
 * register indices, field positions, reset values and timing counts.
 * Assumes it is included by bare name wherever these names are needed.
 */
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define CPC_ADDR_W 18
`define CPC_IDX_W 16
`define CPC_IDX_DIV 16'hc008
`define CPC_IDX_PWR 16'hc00a
`define CPC_IDX_STS 16'hc010
`define CPC_IDX_MSK 16'hc012

// Register widths and reset values.
`define CPC_REG_W 16
`define CPC_DIV_W 4
`define CPC_DIV_RESET 4'hf
`define CPC_PWR_RESET 16'h0000
`define CPC_EN_MASK 16'hfb90

// Power register bit positions.
`define CPC_B_HALT 0
`define CPC_B_SLEEP 1
`define CPC_B_BOOST 2
`define CPC_B_PIN 4
`define CPC_B_HOST 7
`define CPC_B_SPI 8
`define CPC_B_SER 9
`define CPC_B_OTG 11
`define CPC_B_USB 12

// Positions in the synchronised pin vector.
`define CPC_P_USB 0
`define CPC_P_OTGV 4
`define CPC_P_OTGID 5
`define CPC_P_SER 6
`define CPC_P_SPI 7
`define CPC_P_HOST 8
`define CPC_P_GPIO 9
`define CPC_P_BOOST 11
`define CPC_PIN_N 12

// Interrupt status bits.
`define CPC_S_OTG 0
`define CPC_S_SER 1
`define CPC_S_SPI 2
`define CPC_S_HOST 3
`define CPC_S_PIN 4
`define CPC_S_HALT 5
`define CPC_STS_W 6

// Bus responses.
`define CPC_RESP_OK 2'h0
`define CPC_RESP_ERR 2'h2

// Timing: clock period and longest wake-to-execution time.
`define CPC_CLK_NS 10
`define CPC_RESUME_NS 500000
`define CPC_RESUME_CYC (`CPC_RESUME_NS / `CPC_CLK_NS)
`define CPC_CNT_W 16

`endif

// ===== core/cpc_pkg.sv
/*
 * Types of the processor clock divisor and power control block.
 * Assumes cpc_defines.svh is on the include path.
 */
`include "cpc_defines.svh"

package cpc_pkg;

	typedef enum logic [1:0] {
		CPC_RUN,
		CPC_HALT,
		CPC_SLEEP,
		CPC_WAKE
	} cpc_mode_t;

	typedef enum logic [2:0] {
		CPC_R_NONE,
		CPC_R_DIV,
		CPC_R_PWR,
		CPC_R_STS,
		CPC_R_MSK
	} cpc_reg_t;

	typedef struct packed {
		cpc_mode_t mode;
		logic [`CPC_DIV_W-1:0] div;
		logic [`CPC_REG_W-1:0] wake_en;
		logic [`CPC_STS_W-1:0] sts;
		logic [`CPC_STS_W-1:0] msk;
		logic [`CPC_PIN_N-1:0] sync1;
		logic [`CPC_PIN_N-1:0] sync2;
		logic [`CPC_PIN_N-1:0] prev;
		logic [`CPC_CNT_W-1:0] wake_cnt;
		logic otg_irq;
		logic drop_ser;
		logic drop_spi;
		logic aw_got;
		logic w_got;
		logic [`CPC_IDX_W-1:0] awidx;
		logic [`CPC_REG_W-1:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [`CPC_REG_W-1:0] rdata;
		logic [1:0] rresp;
	} cpc_state_t;

	typedef struct packed {
		logic [`CPC_DIV_W-1:0] cnt;
		logic [`CPC_DIV_W-1:0] div;
		logic tick;
	} cpc_div_state_t;

endpackage

// ===== core/cpc_clk_div.sv
/*
 * Processor clock enable divider: one tick every divisor+1 cycles.
 * Assumes a divisor from the register file on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.svh"

module cpc_clk_div (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control.
	input wire logic run,
	input wire logic [`CPC_DIV_W-1:0] divisor,
	// Processor clock enable.
	output logic tick
);

	cpc_pkg::cpc_div_state_t st;
	cpc_pkg::cpc_div_state_t next_st;

	// A new divisor is only taken at the end of a divided period.
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (run) begin
			if (st.cnt == st.div) begin
				next_st.tick = 1'b1;
				next_st.cnt = '0;
				next_st.div = divisor;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.cnt <= '0;
			st.div <= `CPC_DIV_RESET;
			st.tick <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

	a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		st.tick && st.div != '0 |=> !st.tick)
		else $error("processor tick repeated inside a divided period");

	a_div_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
		st.cnt != st.div |=> $stable(st.div))
		else $error("divisor changed inside a divided period");

endmodule
`default_nettype wire

// ===== core/cpc_power_ctrl.sv
/*
 * Processor clock divisor and power control block with an AXI4-Lite
 * register slave, sleep and halt control, wake detection and a
 * sticky wake interrupt. Assumes wake pins are asynchronous and that
 * the interrupt controller gives an enabled-interrupt level on aclk.
 */
// Added by the designer: the AXI4-Lite slave port.
// Summary of operation
// - Divisor N gives processor rate clock/(N+1).
// - Divisor slows the processor only, peripherals full.
// - Sleep, halt and per-source wake enables.
// - Port line transitions wake without processor interrupt.
// - OTG valid or ID change wakes, interrupt.
// - Serial receive transition wakes from sleep.
// - Select falling edge wakes from sleep.
// - Byte causing serial or select wake dropped.
// - Host port read wakes from sleep.
// - Either general pin transition wakes from sleep.
// - Bit two reads booster not ok.
// - Writing sleep stops clock, powers down analog.
// - Sleep freezes counters, timers and PWM levels.
// - Enabled activity ends sleep; resume within bound.
// - Writing halt stops only the processor.
// - Any enabled interrupt ends halt.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.svh"

module cpc_power_ctrl #(
	parameter int unsigned RESUME_CYCLES = `CPC_RESUME_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [`CPC_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels.
	input wire logic [`CPC_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Wake sources and status pins.
	input wire logic [3:0] usb_line,
	input wire logic otg_vbus_valid,
	input wire logic otg_id,
	input wire logic fast_serial_rx,
	input wire logic spi_select_low,
	input wire logic parallel_host_port_rd,
	input wire logic [1:0] gpio_wake_pin,
	input wire logic booster_not_ok,
	// Enabled interrupt from the interrupt controller.
	input wire logic irq_pending,
	// Clock and power controls.
	output logic cpu_clk_en,
	output logic periph_run,
	output logic counters_freeze,
	output logic pwm_hold,
	output logic booster_pd,
	output logic charge_pump_pd,
	output logic usb_xcvr_pd,
	// Wake side effects and interrupt.
	output logic otg_irq_line,
	output logic drop_serial_byte,
	output logic drop_spi_byte,
	output logic irq
);

	cpc_pkg::cpc_state_t st;
	cpc_pkg::cpc_state_t next_st;
	logic div_tick;
	logic sleeping;
	logic [`CPC_PIN_N-1:0] edge_any;
	logic usb_hit;
	logic otg_hit;
	logic ser_hit;
	logic spi_hit;
	logic host_hit;
	logic pin_hit;
	logic wake_hit;
	logic wr_now;
	logic wr_pwr;
	logic [`CPC_REG_W-1:0] wr_val;

	function automatic cpc_pkg::cpc_reg_t reg_decode(
		input logic [`CPC_IDX_W-1:0] idx
	);
		case (idx)
			`CPC_IDX_DIV: reg_decode = cpc_pkg::CPC_R_DIV;
			`CPC_IDX_PWR: reg_decode = cpc_pkg::CPC_R_PWR;
			`CPC_IDX_STS: reg_decode = cpc_pkg::CPC_R_STS;
			`CPC_IDX_MSK: reg_decode = cpc_pkg::CPC_R_MSK;
			default: reg_decode = cpc_pkg::CPC_R_NONE;
		endcase
	endfunction

	// Byte lanes 0 and 1 merge into a 16-bit register.
	function automatic logic [`CPC_REG_W-1:0] lane_merge(
		input logic [`CPC_REG_W-1:0] old,
		input logic [`CPC_REG_W-1:0] val,
		input logic [1:0] strb
	);
		lane_merge = old;
		if (strb[0]) begin
			lane_merge[7:0] = val[7:0];
		end
		if (strb[1]) begin
			lane_merge[15:8] = val[15:8];
		end
	endfunction

	cpc_clk_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(st.mode != cpc_pkg::CPC_SLEEP),
		.divisor(st.div),
		.tick(div_tick)
	);

	assign sleeping = st.mode == cpc_pkg::CPC_SLEEP;
	assign edge_any = st.sync2 ^ st.prev;
	assign wr_now = st.aw_got && st.w_got;
	assign wr_pwr = wr_now && reg_decode(st.awidx) == cpc_pkg::CPC_R_PWR;
	assign wr_val = lane_merge('0, st.wdata, st.wstrb);

	// Wake sources count only while asleep.
	always_comb begin
		usb_hit = |(edge_any[`CPC_P_USB +: 4] & st.wake_en[`CPC_B_USB +: 4]);
		otg_hit = st.wake_en[`CPC_B_OTG] &&
			(edge_any[`CPC_P_OTGV] || edge_any[`CPC_P_OTGID]);
		ser_hit = st.wake_en[`CPC_B_SER] && edge_any[`CPC_P_SER];
		spi_hit = st.wake_en[`CPC_B_SPI] && st.prev[`CPC_P_SPI] &&
			!st.sync2[`CPC_P_SPI];
		host_hit = st.wake_en[`CPC_B_HOST] && !st.prev[`CPC_P_HOST] &&
			st.sync2[`CPC_P_HOST];
		pin_hit = st.wake_en[`CPC_B_PIN] && |edge_any[`CPC_P_GPIO +: 2];
		wake_hit = sleeping && (usb_hit || otg_hit || ser_hit || spi_hit ||
			host_hit || pin_hit);
	end

	always_comb begin
		logic [`CPC_STS_W-1:0] sts_set;
		logic [`CPC_STS_W-1:0] sts_clr;
		sts_set = '0;
		sts_clr = '0;
		next_st = st;
		// Pins pass two flops; the third stage is kept for edges.
		next_st.sync1 = {booster_not_ok, gpio_wake_pin, parallel_host_port_rd,
			spi_select_low, fast_serial_rx, otg_id, otg_vbus_valid, usb_line};
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		next_st.otg_irq = 1'b0;
		next_st.drop_ser = 1'b0;
		next_st.drop_spi = 1'b0;

		// Write address and data are taken in either order.
		if (awvalid && awready) begin
			next_st.aw_got = 1'b1;
			next_st.awidx = awaddr[`CPC_ADDR_W-1:2];
		end
		if (wvalid && wready) begin
			next_st.w_got = 1'b1;
			next_st.wdata = wdata[`CPC_REG_W-1:0];
			next_st.wstrb = wstrb[1:0];
		end
		if (wr_now) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `CPC_RESP_OK;
			case (reg_decode(st.awidx))
				cpc_pkg::CPC_R_DIV: begin
					if (st.wstrb[0]) begin
						next_st.div = wr_val[`CPC_DIV_W-1:0];
					end
				end
				cpc_pkg::CPC_R_PWR: begin
					// Reserved and mode bits are not stored.
					next_st.wake_en = lane_merge(st.wake_en,
						st.wdata & `CPC_EN_MASK, st.wstrb) & `CPC_EN_MASK;
				end
				cpc_pkg::CPC_R_STS: begin
					sts_clr = wr_val[`CPC_STS_W-1:0];
				end
				cpc_pkg::CPC_R_MSK: begin
					next_st.msk = wr_val[`CPC_STS_W-1:0];
				end
				default: begin
					next_st.bresp = `CPC_RESP_ERR;
				end
			endcase
		end else if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken.
		if (arvalid && arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `CPC_RESP_OK;
			case (reg_decode(araddr[`CPC_ADDR_W-1:2]))
				cpc_pkg::CPC_R_DIV: begin
					next_st.rdata = {12'h000, st.div};
				end
				cpc_pkg::CPC_R_PWR: begin
					next_st.rdata = st.wake_en;
					next_st.rdata[`CPC_B_BOOST] = st.sync2[`CPC_P_BOOST];
					next_st.rdata[`CPC_B_SLEEP] = sleeping;
					next_st.rdata[`CPC_B_HALT] = st.mode == cpc_pkg::CPC_HALT;
				end
				cpc_pkg::CPC_R_STS: begin
					next_st.rdata = {10'h000, st.sts};
				end
				cpc_pkg::CPC_R_MSK: begin
					next_st.rdata = {10'h000, st.msk};
				end
				default: begin
					next_st.rdata = '0;
					next_st.rresp = `CPC_RESP_ERR;
				end
			endcase
		end else if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end

		case (st.mode)
			cpc_pkg::CPC_RUN: begin
				if (wr_pwr && wr_val[`CPC_B_SLEEP]) begin
					next_st.mode = cpc_pkg::CPC_SLEEP;
				end else if (wr_pwr && wr_val[`CPC_B_HALT]) begin
					next_st.mode = cpc_pkg::CPC_HALT;
				end
			end
			cpc_pkg::CPC_HALT: begin
				if (irq_pending) begin
					next_st.mode = cpc_pkg::CPC_RUN;
					sts_set[`CPC_S_HALT] = 1'b1;
				end
			end
			cpc_pkg::CPC_SLEEP: begin
				if (wake_hit) begin
					next_st.mode = cpc_pkg::CPC_WAKE;
					next_st.wake_cnt = '0;
				end
				// Port wakes set no status bit and raise nothing.
				next_st.otg_irq = otg_hit;
				next_st.drop_ser = ser_hit;
				next_st.drop_spi = spi_hit;
				sts_set[`CPC_S_OTG] = otg_hit;
				sts_set[`CPC_S_SER] = ser_hit;
				sts_set[`CPC_S_SPI] = spi_hit;
				sts_set[`CPC_S_HOST] = host_hit;
				sts_set[`CPC_S_PIN] = pin_hit;
			end
			cpc_pkg::CPC_WAKE: begin
				// Clocks run again; the processor waits for the rails.
				if (st.wake_cnt >= `CPC_CNT_W'(RESUME_CYCLES - 1)) begin
					next_st.mode = cpc_pkg::CPC_RUN;
				end else begin
					next_st.wake_cnt = st.wake_cnt + 1'b1;
				end
			end
			default: begin
				next_st.mode = cpc_pkg::CPC_RUN;
			end
		endcase

		// A new event wins over a clear in the same cycle.
		next_st.sts = (st.sts & ~sts_clr) | sts_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.mode <= cpc_pkg::CPC_RUN;
			st.div <= `CPC_DIV_RESET;
			st.wake_en <= `CPC_PWR_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign awready = !st.aw_got && !st.bvalid;
	assign wready = !st.w_got && !st.bvalid;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = !st.rvalid;
	assign rvalid = st.rvalid;
	assign rresp = st.rresp;
	assign rdata = {16'h0000, st.rdata};

	// Only the processor sees the divided rate.
	assign cpu_clk_en = div_tick && st.mode == cpc_pkg::CPC_RUN;
	assign periph_run = !sleeping;
	assign counters_freeze = sleeping;
	assign pwm_hold = sleeping;
	assign booster_pd = sleeping;
	assign charge_pump_pd = sleeping;
	assign usb_xcvr_pd = sleeping;
	assign otg_irq_line = st.otg_irq;
	assign drop_serial_byte = st.drop_ser;
	assign drop_spi_byte = st.drop_spi;
	assign irq = |(st.sts & st.msk);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_sleep_entry: assert property (
		st.mode == cpc_pkg::CPC_RUN && wr_pwr && wr_val[`CPC_B_SLEEP]
		|=> sleeping && booster_pd && usb_xcvr_pd && !cpu_clk_en)
		else $error("sleep write did not stop the chip");

	a_halt_entry: assert property (
		st.mode == cpc_pkg::CPC_RUN && wr_pwr && wr_val[1:0] == 2'h1
		|=> st.mode == cpc_pkg::CPC_HALT && periph_run)
		else $error("halt write did not stop only the processor");

	a_halt_exit: assert property (
		st.mode == cpc_pkg::CPC_HALT && irq_pending
		|=> st.mode == cpc_pkg::CPC_RUN && st.sts[`CPC_S_HALT])
		else $error("enabled interrupt did not end halt");

	a_halt_quiet: assert property (
		st.mode != cpc_pkg::CPC_RUN |-> !cpu_clk_en)
		else $error("processor clocked outside run");

	a_sleep_freeze: assert property (
		sleeping |-> counters_freeze && pwm_hold && !periph_run)
		else $error("sleep left counters or pwm running");

	a_port_quiet: assert property (
		sleeping && usb_hit && !otg_hit |=> !otg_irq_line)
		else $error("port wake raised an interrupt");

	a_otg_wake: assert property (
		sleeping && otg_hit |=> otg_irq_line && st.mode == cpc_pkg::CPC_WAKE)
		else $error("otg change did not wake with interrupt");

	a_byte_drop: assert property (
		sleeping && (ser_hit || spi_hit)
		|=> drop_serial_byte || drop_spi_byte)
		else $error("waking byte not dropped");

	a_resume_bound: assert property (
		st.mode == cpc_pkg::CPC_WAKE |-> st.wake_cnt < `CPC_CNT_W'(RESUME_CYCLES))
		else $error("resume took longer than allowed");

	a_reserved_zero: assert property (
		st.rvalid |-> rdata[31:16] == 16'h0000 &&
			(st.wake_en & ~`CPC_EN_MASK) == '0)
		else $error("reserved bits not zero");

endmodule
`default_nettype wire

// ===== sim/tb_top.sv
/*
 * Self-checking testbench of the processor clock divisor and power block.
 * Assumes the core files and cpc_defines.svh are compiled beforehand.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.svh"

module tb_top;
	localparam int RESUME = 20;
	localparam logic [17:0] A_DIV = {`CPC_IDX_DIV, 2'b00};
	localparam logic [17:0] A_PWR = {`CPC_IDX_PWR, 2'b00};
	localparam logic [17:0] A_STS = {`CPC_IDX_STS, 2'b00};
	localparam logic [17:0] A_MSK = {`CPC_IDX_MSK, 2'b00};
	localparam logic [15:0] WEN[6] = '{16'h4000, 16'h0800, 16'h0200,
		16'h0100, 16'h0080, 16'h0010};
	localparam logic [5:0] WST[6] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
	logic aclk = 0, aresetn = 0;
	logic [17:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0, usb_line = 0;
	logic otg_vbus_valid = 0, otg_id = 0, fast_serial_rx = 0;
	logic spi_select_low = 1, parallel_host_port_rd = 0;
	logic [1:0] gpio_wake_pin = 0;
	logic booster_not_ok = 1, irq_pending = 0;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic cpu_clk_en, periph_run, counters_freeze, pwm_hold, booster_pd;
	wire logic charge_pump_pd, usb_xcvr_pd, otg_irq_line, irq;
	wire logic drop_serial_byte, drop_spi_byte;
	int n_otg = 0, n_ser = 0, n_spi = 0;
	int bad_count = 0, n_checks = 0;
	logic [31:0] rd;
	logic [1:0] rs;

	cpc_power_ctrl #(.RESUME_CYCLES(RESUME)) DUT (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.usb_line(usb_line), .otg_vbus_valid(otg_vbus_valid),
		.otg_id(otg_id), .fast_serial_rx(fast_serial_rx),
		.spi_select_low(spi_select_low),
		.parallel_host_port_rd(parallel_host_port_rd),
		.gpio_wake_pin(gpio_wake_pin), .booster_not_ok(booster_not_ok),
		.irq_pending(irq_pending), .cpu_clk_en(cpu_clk_en),
		.periph_run(periph_run), .counters_freeze(counters_freeze),
		.pwm_hold(pwm_hold), .booster_pd(booster_pd),
		.charge_pump_pd(charge_pump_pd), .usb_xcvr_pd(usb_xcvr_pd),
		.otg_irq_line(otg_irq_line), .drop_serial_byte(drop_serial_byte),
		.drop_spi_byte(drop_spi_byte), .irq(irq));

	always #5 aclk = ~aclk;

	// One-cycle pulses are counted here so a scenario can judge them later.
	always @(posedge aclk) begin
		if (otg_irq_line === 1'b1) n_otg <= n_otg + 1;
		if (drop_serial_byte === 1'b1) n_ser <= n_ser + 1;
		if (drop_spi_byte === 1'b1) n_spi <= n_spi + 1;
	end

	task automatic conclude();
		if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	task automatic wr(input logic [17:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic pa, pw, ta, tw, hb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		pa = 1;
		pw = 1;
		hb = 0;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge aclk);
			if (ta) begin awvalid <= 0; pa = 0; end
			if (tw) begin wvalid <= 0; pw = 0; end
		end
		while (!hb) begin
			@(negedge aclk);
			hb = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 0;
	endtask

	task automatic rdr(input logic [17:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, hr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		ta = 0;
		hr = 0;
		while (!ta) begin
			@(negedge aclk);
			ta = arready;
			@(posedge aclk);
		end
		arvalid <= 0;
		while (!hr) begin
			@(negedge aclk);
			hr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 0;
	endtask

	// Cycles from one processor tick to the next.
	task automatic tick_gap(output int g);
		int i;
		for (i = 0; i < 40 && cpu_clk_en !== 1'b1; i++) @(negedge aclk);
		g = 0;
		do begin
			@(negedge aclk);
			g++;
		end while (cpu_clk_en !== 1'b1 && g < 40);
	endtask

	task automatic t_regs();
		int g, k;
		logic [3:0] nv[3] = '{4'h0, 4'h3, 4'hf};
		rdr(A_DIV, rd, rs);
		chk("div reset", 32'h0000_000f, rd);
		rdr(A_PWR, rd, rs);
		chk("booster bad", 32'h0000_0004, rd);
		booster_not_ok <= 0;
		repeat (4) @(posedge aclk);
		rdr(A_PWR, rd, rs);
		chk("booster ok", 32'h0000_0000, rd);
		rdr({16'hc00c, 2'b00}, rd, rs);
		chk("unmapped rresp", `CPC_RESP_ERR, rs);
		wr({16'hc00c, 2'b00}, 32'h0000_ffff, rs);
		chk("unmapped bresp", `CPC_RESP_ERR, rs);
		for (k = 0; k < 3; k++) begin
			wr(A_DIV, {28'h000_0000, nv[k]}, rs);
			chk("div bresp", `CPC_RESP_OK, rs);
			tick_gap(g);
			tick_gap(g);
			chk("tick gap", 32'(nv[k]) + 1, 32'(g));
			chk("periph run", 1, periph_run);
		end
		rdr(A_DIV, rd, rs);
		chk("div reserved", 32'h0000_000f, rd);
		wr(A_DIV, 32'h0000_0000, rs);
	endtask

	task automatic t_halt();
		int i, n;
		wr(A_MSK, 32'h0000_0020, rs);
		wr(A_PWR, 32'h0000_0001, rs);
		rdr(A_PWR, rd, rs);
		chk("halt read", 32'h0000_0001, rd);
		n = 0;
		for (i = 0; i < 20; i++) begin
			@(negedge aclk);
			n += (cpu_clk_en === 1'b1);
		end
		chk("halt ticks", 0, n);
		chk("halt periph", 1, periph_run);
		@(posedge aclk);
		irq_pending <= 1;
		@(posedge aclk);
		irq_pending <= 0;
		for (i = 0; i < 5 && cpu_clk_en !== 1'b1; i++) @(negedge aclk);
		chk("halt exit", 1, cpu_clk_en);
		rdr(A_STS, rd, rs);
		chk("halt status", 32'h0000_0020, rd);
		chk("irq raised", 1, irq);
		wr(A_STS, 32'h0000_0020, rs);
		@(negedge aclk);
		chk("irq cleared", 0, irq);
	endtask

	task automatic t_wake(input int k);
		int i, n, o0, s0, p0;
		@(negedge aclk);
		o0 = n_otg;
		s0 = n_ser;
		p0 = n_spi;
		wr(A_PWR, {16'h0000, WEN[k] | 16'h0002}, rs);
		repeat (2) @(negedge aclk);
		chk("sleep outs", 6'h1f, {periph_run, counters_freeze, pwm_hold,
			booster_pd, charge_pump_pd, usb_xcvr_pd});
		@(posedge aclk);
		usb_line[0] <= ~usb_line[0];
		n = 0;
		for (i = 0; i < 8; i++) begin
			@(negedge aclk);
			n += (cpu_clk_en === 1'b1);
		end
		chk("no tick asleep", 0, n);
		chk("still asleep", 0, periph_run);
		@(posedge aclk);
		case (k)
			0: usb_line[2] <= ~usb_line[2];
			1: otg_id <= ~otg_id;
			2: fast_serial_rx <= ~fast_serial_rx;
			3: spi_select_low <= 0;
			4: parallel_host_port_rd <= 1;
			default: gpio_wake_pin[1] <= ~gpio_wake_pin[1];
		endcase
		for (i = 0; i < 8 && periph_run !== 1'b1; i++) @(negedge aclk);
		chk("woken", 1, periph_run);
		for (i = 0; i < RESUME + 8 && cpu_clk_en !== 1'b1; i++) @(negedge aclk);
		chk("resumed", 1, cpu_clk_en);
		@(negedge aclk);
		chk("otg pulses", k == 1, n_otg - o0);
		chk("serial drops", k == 2, n_ser - s0);
		chk("select drops", k == 3, n_spi - p0);
		rdr(A_STS, rd, rs);
		chk("wake status", 32'(WST[k]), rd);
		chk("irq masked", k == 2, irq);
		wr(A_STS, 32'h0000_003f, rs);
		spi_select_low <= 1;
		parallel_host_port_rd <= 0;
		@(negedge aclk);
		chk("irq off", 0, irq);
	endtask

	initial begin
		#500_000;
		bad_count++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		repeat (4) @(posedge aclk);
		t_regs();
		t_halt();
		wr(A_MSK, 32'h0000_0002, rs);
		for (int k = 0; k < 6; k++) t_wake(k);
		conclude();
	end
endmodule
`default_nettype wire
